// ### src/csr_pkg.sv
// Shared constants of the codec serial receiver and clock generator
package csr_pkg;
   // ************************************************************
   // Register addresses
   // ************************************************************
   localparam logic [15:0] CFG_ADDR = 16'hffd0;
   localparam logic [15:0] CTL_ADDR = 16'hffd1;
   localparam logic [15:0] STAT_ADDR = 16'hfff0;
   localparam logic [15:0] RCV_ADDR = 16'hfff1;

   // ************************************************************
   // Clock and frame configuration fields
   // ************************************************************
   localparam int CFG_PM_LSB = 0;
   localparam int CFG_PM_MSB = 7;
   localparam int CFG_DC_LSB = 8;
   localparam int CFG_DC_MSB = 10;
   localparam int CFG_WL_LSB = 13;
   localparam int CFG_WL_MSB = 14;
   localparam int CFG_RANGE = 15;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [15:0] CFG_WMASK = 16'he7ff;

   // ************************************************************
   // Mode control fields
   // ************************************************************
   localparam int CTL_RCV_IRQ_EN = 15;
   localparam int CTL_RECEIVE_ENABLE = 13;
   localparam int CTL_NETWORK = 11;
   localparam int CTL_PORT_ENABLE = 10;
   localparam int CTL_FS_INVERT = 9;
   localparam int CTL_FS_LENGTH = 8;
   localparam int CTL_BIT_ORDER = 7;
   localparam int CTL_CLK_POL = 6;
   localparam int CTL_CLK_DIR = 5;
   localparam int CTL_FS_DIR = 4;
   localparam int CTL_GATED = 3;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   localparam logic [15:0] CTL_WMASK = 16'haff8;

   // ************************************************************
   // Status fields
   // ************************************************************
   localparam int STAT_RCV_FULL = 7;

   // ************************************************************
   // Word lengths
   // ************************************************************
   localparam logic [1:0] WL_8 = 2'h0;
   localparam logic [1:0] WL_12 = 2'h2;
   localparam logic [1:0] WL_16 = 2'h3;
   localparam logic [4:0] LEN_8 = 5'h08;
   localparam logic [4:0] LEN_12 = 5'h0c;
   localparam logic [4:0] LEN_16 = 5'h10;

   // ************************************************************
   // Divider chain moduli and counter presets
   // ************************************************************
   localparam logic [7:0] HALF_MOD = 8'h01;
   localparam logic [7:0] RANGE_MOD = 8'h07;
   localparam logic [7:0] BYPASS_MOD = 8'h00;
   localparam logic [4:0] GEN_BIT_LAST = 5'h0f;
   localparam logic [2:0] GEN_WORD_LAST = 3'h7;
endpackage : csr_pkg

// ### src/csr_div.sv
// Enable-pulse divider stage of the bit clock chain
module csr_div (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic clr_in,
   input wire logic en_in,
   input wire logic [7:0] mod_in,
   output logic tick_out
);
   typedef struct packed {
      logic [7:0] cnt;
   } csr_div_state_t;

   csr_div_state_t q;
   csr_div_state_t s;

   // One pulse per mod_in+1 input pulses
   assign tick_out = en_in && (q.cnt == 8'h00);

   // Count down, reload on the tick
   always_comb begin
      s = q;
      if (clr_in) begin
         s.cnt = 8'h00;
      end else if (en_in) begin
         if (q.cnt == 8'h00) begin
            s.cnt = mod_in;
         end else begin
            s.cnt = q.cnt - 8'h01;
         end
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         q <= '0;
      end else begin
         q <= s;
      end
   end
endmodule : csr_div

// ### src/csr_serial_receiver.sv
// Serial receive path with bit clock and frame sync generator
// Operation
// - Sixteen-bit shift register collects bits from the serial receive pin.
// - Continuous clock: shifting starts on a selected clock edge with frame sync asserted, then runs to the word end.
// - Gated clock: shift on every selected clock edge, no frame sync needed.
// - Bit order control clear means first bit is MSB, set means LSB.
// - Transfer to the holding register after word length bits shifted in.
// - Holding register is sixteen bits, read-only, loaded whenever shift register fills.
// - Short words are left-aligned, unused low bits read as zero.
// - Receive interrupt raised when holding register fills and interrupt enabled.
// - Processor reset clears configuration; local and stop resets keep it.
// - Prescale modulus in bits 0..7 divides by its value plus one.
// - Prescaler divides the core clock, used only with internal clock.
// - Generated bit clock drives the clock pin and the shift registers.
// - Bit clock equals oscillator over four times range factor times modulus plus one.
// - Frame rate divider in bits 8..10 divides word clock by code plus one.
// - Network mode: divider gives slots per frame, software uses codes 1..7.
// - Word length in bits 13..14: 00 eight, 10 twelve, 11 sixteen bits.
// - Word length sets word divider and word-long frame sync length.
// - Range bit 15 inserts a fixed divide-by-eight stage, clear bypasses it.
// - Internal bit clock never exceeds a quarter of the oscillator rate.
// - Clearing port enable resets status bits and keeps control bits.
// - Frame sync length bit set gives one-bit sync, clear gives one-word sync.
// - Receive enable clear blocks transfers and discards the word in progress.
//
// The address-and-strobe port was decided locally.
module csr_serial_receiver (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [15:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   input wire logic serial_rx_pin_in,
   input wire logic sck_in,
   input wire logic fs_in,
   output logic sck_out,
   output logic sck_oe_out,
   output logic fs_out,
   output logic fs_oe_out,
   output logic rcv_irq_out
);
   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [15:0] cfg;
      logic [15:0] ctl;
      logic [15:0] rcv_word;
      logic [15:0] rdata;
      logic [15:0] sh;
      logic rcv_full;
      logic xfer;
      logic [4:0] bit_cnt;
      logic active;
      logic [2:0] slot_cnt;
      logic sck_int;
      logic sck_prev;
      logic [4:0] gen_bit;
      logic [2:0] gen_word;
      logic fs_int;
      logic irq;
      logic sck_o;
      logic sck_oe;
      logic fs_o;
      logic fs_oe;
   } csr_state_t;

   csr_state_t q;
   csr_state_t s;
   logic gen_run;
   logic tick_half;
   logic tick_range;
   logic tick_bit;
   logic [7:0] range_mod;
   logic [4:0] q_wlen;

   // Word length decode, reserved code falls back to eight bits
   function automatic logic [4:0] wlen_of(input logic [1:0] code);
      case (code)
         csr_pkg::WL_12: wlen_of = csr_pkg::LEN_12;
         csr_pkg::WL_16: wlen_of = csr_pkg::LEN_16;
         default: wlen_of = csr_pkg::LEN_8;
      endcase
   endfunction : wlen_of

   assign q_wlen = wlen_of(q.cfg[csr_pkg::CFG_WL_MSB:csr_pkg::CFG_WL_LSB]);

   // ************************************************************
   // Bit clock divider chain
   // ************************************************************
   // Runs only for the internal clock; gated mode also needs receive enable
   assign gen_run = q.ctl[csr_pkg::CTL_PORT_ENABLE] && q.ctl[csr_pkg::CTL_CLK_DIR] &&
      (!q.ctl[csr_pkg::CTL_GATED] || q.ctl[csr_pkg::CTL_RECEIVE_ENABLE]);
   assign range_mod = q.cfg[csr_pkg::CFG_RANGE] ? csr_pkg::RANGE_MOD :
      csr_pkg::BYPASS_MOD;

   // Half of the fixed divide by four
   csr_div u_half (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .clr_in(!gen_run),
      .en_in(gen_run),
      .mod_in(csr_pkg::HALF_MOD),
      .tick_out(tick_half)
   );

   // Optional divide by eight
   csr_div u_range (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .clr_in(!gen_run),
      .en_in(tick_half),
      .mod_in(range_mod),
      .tick_out(tick_range)
   );

   // Variable prescaler, modulus plus one
   csr_div u_prescale (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .clr_in(!gen_run),
      .en_in(tick_range),
      .mod_in(q.cfg[csr_pkg::CFG_PM_MSB:csr_pkg::CFG_PM_LSB]),
      .tick_out(tick_bit)
   );

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic en;
      logic [4:0] wlen;
      logic [2:0] dc;
      logic rise;
      logic fall;
      logic latch;
      logic launch;
      logic fs_act;
      logic [15:0] shv;
      logic [15:0] shifted;
      logic [4:0] cnt0;
      en = q.ctl[csr_pkg::CTL_PORT_ENABLE];
      wlen = q_wlen;
      dc = q.cfg[csr_pkg::CFG_DC_MSB:csr_pkg::CFG_DC_LSB];
      rise = 1'b0;
      fall = 1'b0;
      latch = 1'b0;
      launch = 1'b0;
      fs_act = 1'b0;
      shv = 16'h0000;
      shifted = 16'h0000;
      cnt0 = 5'h00;
      s = q;
      s.xfer = 1'b0;
      s.rdata = 16'h0000;
      s.sck_prev = sck_in;

      // Register writes, reserved bits forced to zero
      if (wr_in) begin
         case (addr_in)
            csr_pkg::CFG_ADDR: s.cfg = wdata_in & csr_pkg::CFG_WMASK;
            csr_pkg::CTL_ADDR: s.ctl = wdata_in & csr_pkg::CTL_WMASK;
            default: s.cfg = q.cfg;
         endcase
      end

      // Register reads, data in the next cycle
      if (rd_in) begin
         case (addr_in)
            csr_pkg::CFG_ADDR: s.rdata = q.cfg;
            csr_pkg::CTL_ADDR: s.rdata = q.ctl;
            csr_pkg::STAT_ADDR: s.rdata[csr_pkg::STAT_RCV_FULL] = q.rcv_full;
            csr_pkg::RCV_ADDR: begin
               s.rdata = q.rcv_word;
               s.rcv_full = 1'b0;
            end
            default: s.rdata = 16'h0000;
         endcase
      end

      // Internal bit clock toggles on each prescaler pulse
      if (!gen_run) begin
         s.sck_int = 1'b0;
      end else if (tick_bit) begin
         s.sck_int = !q.sck_int;
      end

      // Edge selection from internal or external clock
      if (q.ctl[csr_pkg::CTL_CLK_DIR]) begin
         rise = tick_bit && !q.sck_int;
         fall = tick_bit && q.sck_int;
      end else begin
         rise = sck_in && !q.sck_prev;
         fall = !sck_in && q.sck_prev;
      end
      latch = q.ctl[csr_pkg::CTL_CLK_POL] ? rise : fall;
      launch = q.ctl[csr_pkg::CTL_CLK_POL] ? fall : rise;

      // Frame sync generator, word divider and frame rate divider
      if (!en) begin
         s.gen_bit = csr_pkg::GEN_BIT_LAST;
         s.gen_word = csr_pkg::GEN_WORD_LAST;
         s.fs_int = 1'b0;
      end else if (launch) begin
         if (q.gen_bit >= wlen - 5'h01) begin
            s.gen_bit = 5'h00;
            s.gen_word = (q.gen_word >= dc) ? 3'h0 : q.gen_word + 3'h1;
         end else begin
            s.gen_bit = q.gen_bit + 5'h01;
         end
         if (q.ctl[csr_pkg::CTL_FS_LENGTH]) begin
            s.fs_int = (s.gen_word == 3'h0) && (s.gen_bit == 5'h00);
         end else begin
            s.fs_int = (s.gen_word == 3'h0);
         end
      end

      // Frame sync seen by the receiver, active high
      fs_act = q.ctl[csr_pkg::CTL_FS_DIR] ? q.fs_int :
         (fs_in ^ q.ctl[csr_pkg::CTL_FS_INVERT]);

      // Receive shifter
      if (!en || !q.ctl[csr_pkg::CTL_RECEIVE_ENABLE]) begin
         s.active = 1'b0;
         s.bit_cnt = 5'h00;
         s.slot_cnt = 3'h0;
      end else if (latch && (q.active || q.ctl[csr_pkg::CTL_GATED] || fs_act)) begin
         cnt0 = q.active ? q.bit_cnt : 5'h00;
         shv = (cnt0 == 5'h00) ? 16'h0000 : q.sh;
         if (!q.active) begin
            s.slot_cnt = 3'h0;
         end
         if (q.ctl[csr_pkg::CTL_BIT_ORDER]) begin
            shifted = {serial_rx_pin_in, shv[15:1]};
         end else begin
            shifted = {shv[14:0], serial_rx_pin_in};
         end
         s.sh = shifted;
         s.active = 1'b1;
         if (cnt0 + 5'h01 == wlen) begin
            s.xfer = 1'b1;
            s.rcv_full = 1'b1;
            s.bit_cnt = 5'h00;
            if (q.ctl[csr_pkg::CTL_BIT_ORDER]) begin
               s.rcv_word = shifted;
            end else begin
               case (wlen)
                  csr_pkg::LEN_12: s.rcv_word = {shifted[11:0], 4'h0};
                  csr_pkg::LEN_16: s.rcv_word = shifted;
                  default: s.rcv_word = {shifted[7:0], 8'h00};
               endcase
            end
            if (q.ctl[csr_pkg::CTL_GATED]) begin
               s.active = 1'b1;
            end else if (q.ctl[csr_pkg::CTL_NETWORK] && (s.slot_cnt < dc)) begin
               s.slot_cnt = s.slot_cnt + 3'h1;
            end else begin
               s.active = 1'b0;
               s.slot_cnt = 3'h0;
            end
         end else begin
            s.bit_cnt = cnt0 + 5'h01;
         end
      end

      // Port disable presets status, keeps control
      if (!en) begin
         s.rcv_full = 1'b0;
      end

      // Registered outputs
      s.irq = s.rcv_full && s.ctl[csr_pkg::CTL_RCV_IRQ_EN];
      s.sck_o = s.sck_int;
      s.sck_oe = s.ctl[csr_pkg::CTL_PORT_ENABLE] && s.ctl[csr_pkg::CTL_CLK_DIR];
      s.fs_o = s.fs_int ^ s.ctl[csr_pkg::CTL_FS_INVERT];
      s.fs_oe = s.ctl[csr_pkg::CTL_PORT_ENABLE] && s.ctl[csr_pkg::CTL_FS_DIR];
   end

   // State register, processor reset clears everything but gen_bit and gen_word, which it presets to their last values
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         q <= '0;
         q.cfg <= csr_pkg::CFG_RESET;
         q.ctl <= csr_pkg::CTL_RESET;
         q.gen_bit <= csr_pkg::GEN_BIT_LAST;
         q.gen_word <= csr_pkg::GEN_WORD_LAST;
      end else begin
         q <= s;
      end
   end

   assign rdata_out = q.rdata;
   assign sck_out = q.sck_o;
   assign sck_oe_out = q.sck_oe;
   assign fs_out = q.fs_o;
   assign fs_oe_out = q.fs_oe;
   assign rcv_irq_out = q.irq;

   // ************************************************************
   // Assertions
   // ************************************************************
   a_xfer_sets_full: assert property (@(posedge clk_in) disable iff (srst_in)
      q.xfer |-> q.rcv_full)
      else $error("transfer did not set receive full");

   a_xfer_word_count: assert property (@(posedge clk_in) disable iff (srst_in)
      q.xfer |-> ($past(q.bit_cnt) + 5'h01 == q_wlen))
      else $error("transfer after wrong bit count");

   a_low_bits_zero: assert property (@(posedge clk_in) disable iff (srst_in)
      (q.xfer && (q_wlen == csr_pkg::LEN_8)) |-> (q.rcv_word[7:0] == 8'h00))
      else $error("short word low bits not zero");

   a_irq_on_full: assert property (@(posedge clk_in) disable iff (srst_in)
      (q.xfer && q.ctl[csr_pkg::CTL_RCV_IRQ_EN]) |-> rcv_irq_out)
      else $error("receive interrupt missing");

   a_read_clears: assert property (@(posedge clk_in) disable iff (srst_in)
      (rd_in && (addr_in == csr_pkg::RCV_ADDR) && !s.xfer) |=> !q.rcv_full)
      else $error("read did not clear receive full");

   a_disable_clears: assert property (@(posedge clk_in) disable iff (srst_in)
      $fell(q.ctl[csr_pkg::CTL_PORT_ENABLE]) |=> (!q.rcv_full && !q.active))
      else $error("port disable left status set");

   a_cfg_kept: assert property (@(posedge clk_in) disable iff (srst_in)
      (!q.ctl[csr_pkg::CTL_PORT_ENABLE] && !wr_in) |=> $stable(q.cfg))
      else $error("configuration changed without write");

   a_sck_half_min: assert property (@(posedge clk_in) disable iff (srst_in)
      ($changed(q.sck_int) && gen_run) |=> ($stable(q.sck_int) || !gen_run))
      else $error("bit clock faster than quarter rate");

   a_fs_one_bit: assert property (@(posedge clk_in) disable iff (srst_in)
      (q.fs_int && q.ctl[csr_pkg::CTL_FS_LENGTH]) |->
      (q.gen_bit == 5'h00 && q.gen_word == 3'h0))
      else $error("bit-long frame sync too long");

   a_block_disabled: assert property (@(posedge clk_in) disable iff (srst_in)
      !q.ctl[csr_pkg::CTL_RECEIVE_ENABLE] |=> !q.xfer)
      else $error("transfer while receive disabled");

   a_sck_pin: assert property (@(posedge clk_in) disable iff (srst_in)
      (sck_oe_out && $past(tick_bit)) |-> (sck_out != $past(sck_out)))
      else $error("clock pin missed a prescaler pulse");
endmodule : csr_serial_receiver

// ### test/csr_codec_model.sv
// Behavioural codec that clocks serial words into the receiver
module csr_codec_model #(
   parameter int HALF = 4
) (
   input wire logic clk_in,
   output logic sck_out,
   output logic fs_out,
   output logic data_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // ************************************************************
   // Idle levels
   // ************************************************************
   initial begin
      sck_out = 1'b0;
      fs_out = 1'b0;
      data_out = 1'b0;
   end

   // ************************************************************
   // One word, launched on falling edges, latched on rising edges
   // ************************************************************
   task automatic send(input logic [15:0] v, input int n, input bit lsb, input bit with_fs);
      int k;
      for (k = 0; k < n; k++) begin
         @(posedge clk_in);
         data_out <= lsb ? v[k] : v[n-1-k];
         fs_out <= with_fs && (k == 0); // One-bit sync marks the first bit
         repeat (HALF) @(posedge clk_in);
         sck_out <= 1'b1;
         repeat (HALF) @(posedge clk_in);
         sck_out <= 1'b0;
      end
      @(posedge clk_in);
      data_out <= ~data_out; // Stale data must not look valid
      fs_out <= 1'b0;
   endtask : send
endmodule : csr_codec_model

// ### test/codec_serial_rx_clockgen_tb.sv
// Self-checking testbench of the codec serial receiver
module codec_serial_rx_clockgen_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [15:0] addr_in = 16'h0000;
   logic [15:0] wdata_in = 16'h0000;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [15:0] rdata_out;
   logic sck_in;
   logic fs_in;
   logic ser_data;
   logic sck_out;
   logic sck_oe_out;
   logic fs_out;
   logic fs_oe_out;
   logic rcv_irq_out;
   int fail_count = 0;
   int n_compared = 0;
   int i, n, per, hi;
   logic [15:0] v, e;
   logic [15:0] icfg [5] = '{16'h0100, 16'h4202, 16'h8101, 16'h00ff, 16'h6301};
   logic [15:0] ictl [5] = '{16'h2530, 16'h2430, 16'h2530, 16'h2530, 16'h2d30};
   int sckp [5] = '{4, 12, 64, 1024, 8};
   int fsp [5] = '{64, 432, 1024, 0, 512};
   int fsh [5] = '{4, 144, 64, 0, 8};

   // ************************************************************
   // Clock, design and codec
   // ************************************************************
   always #50 clk_in = ~clk_in;

   csr_serial_receiver dut_u (
      .clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .serial_rx_pin_in(ser_data),
      .sck_in(sck_in), .fs_in(fs_in), .sck_out(sck_out), .sck_oe_out(sck_oe_out),
      .fs_out(fs_out), .fs_oe_out(fs_oe_out), .rcv_irq_out(rcv_irq_out)
   );

   csr_codec_model model_u (.clk_in(clk_in), .sck_out(sck_in), .fs_out(fs_in), .data_out(ser_data));

   // ************************************************************
   // Compare, bus cycles, measurement
   // ************************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr

   task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 check(rdata_out, exp);
   endtask : rchk

   task automatic cfgset(input logic [15:0] cfg, input logic [15:0] ctl);
      wr(csr_pkg::CTL_ADDR, 16'h0000); // Local reset before mode change
      wr(csr_pkg::CFG_ADDR, cfg);
      wr(csr_pkg::CTL_ADDR, ctl);
   endtask : cfgset

   task automatic settle();
      repeat (4) @(posedge clk_in);
      #1;
   endtask : settle

   task automatic measure(input bit use_fs, output int period, output int high);
      int c, seen;
      logic s, p;
      seen = 0;
      p = 1'b1;
      period = 0;
      high = 0;
      for (c = 0; c < 3000 && seen < 2; c++) begin
         @(posedge clk_in);
         #1 s = use_fs ? fs_out : sck_out;
         if (s === 1'b1 && p === 1'b0) seen++;
         if (seen == 1) begin
            period++;
            if (s === 1'b1) high++;
         end
         p = s;
      end
   endtask : measure

   task automatic tally_and_finish();
      if (fail_count == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // ************************************************************
   // Watchdog
   // ************************************************************
   initial begin
      repeat (40000) @(posedge clk_in);
      fail_count++;
      tally_and_finish();
   end

   // ************************************************************
   // Test sequence
   // ************************************************************
   initial begin
      repeat (20) @(posedge clk_in);
      srst_in <= 1'b0;
      rchk(csr_pkg::CFG_ADDR, 16'h0000);
      rchk(csr_pkg::STAT_ADDR, 16'h0000);
      rchk(16'hff00, 16'h0000); // Unmapped
      wr(csr_pkg::CFG_ADDR, 16'hffff);
      rchk(csr_pkg::CFG_ADDR, 16'he7ff);
      // Word lengths and bit orders, interrupt disabled on the last
      for (i = 0; i < 6; i++) begin
         n = (i < 2) ? 8 : (i < 4) ? 12 : 16;
         cfgset((i < 2) ? 16'h0000 : (i < 4) ? 16'h4000 : 16'h6000,
            16'h2540 | ((i < 5) ? 16'h8000 : 16'h0000) | (i[0] ? 16'h0080 : 16'h0000));
         v = 16'(32'hc3a5 & ((1 << n) - 1));
         e = 16'(v << (16 - n));
         model_u.send(v, n, i[0], 1'b1);
         settle();
         check({15'h0000, rcv_irq_out}, (i < 5) ? 16'h0001 : 16'h0000);
         rchk(csr_pkg::STAT_ADDR, 16'h0080);
         if (i == 0) wr(csr_pkg::RCV_ADDR, 16'h1234); // Read-only holding word
         rchk(csr_pkg::RCV_ADDR, e);
         rchk(csr_pkg::STAT_ADDR, 16'h0000);
         check({15'h0000, rcv_irq_out}, 16'h0000);
      end
      // Continuous clock without frame sync shifts nothing
      cfgset(16'h0000, 16'h2540);
      model_u.send(16'h005a, 8, 1'b0, 1'b0);
      settle();
      rchk(csr_pkg::STAT_ADDR, 16'h0000);
      // Gated clock needs no frame sync, words back to back
      cfgset(16'h0000, 16'h2548);
      model_u.send(16'h005a, 8, 1'b0, 1'b0);
      settle();
      rchk(csr_pkg::RCV_ADDR, 16'h5a00);
      model_u.send(16'h00c3, 8, 1'b0, 1'b0);
      settle();
      rchk(csr_pkg::RCV_ADDR, 16'hc300);
      // Network mode, latch on falling edge: sync word plus one slot, then nothing
      cfgset(16'h0100, 16'h2d00);
      model_u.send(16'h005a, 8, 1'b0, 1'b1);
      settle();
      rchk(csr_pkg::RCV_ADDR, 16'h5a00);
      model_u.send(16'h00c3, 8, 1'b0, 1'b0);
      settle();
      rchk(csr_pkg::RCV_ADDR, 16'hc300);
      model_u.send(16'h0011, 8, 1'b0, 1'b0);
      settle();
      rchk(csr_pkg::STAT_ADDR, 16'h0000);
      // Receive enable dropped mid-word discards it
      cfgset(16'h6000, 16'ha540);
      fork
         model_u.send(16'hbeef, 16, 1'b0, 1'b1);
         begin
            repeat (60) @(posedge clk_in);
            wr(csr_pkg::CTL_ADDR, 16'h8540);
         end
      join
      settle();
      rchk(csr_pkg::STAT_ADDR, 16'h0000);
      wr(csr_pkg::CTL_ADDR, 16'ha540);
      model_u.send(16'h1357, 16, 1'b0, 1'b1);
      settle();
      rchk(csr_pkg::RCV_ADDR, 16'h1357);
      // Port-local reset keeps control, clears status
      cfgset(16'h6301, 16'h2540);
      model_u.send(16'h2468, 16, 1'b0, 1'b1);
      settle();
      wr(csr_pkg::CTL_ADDR, 16'h2140);
      rchk(csr_pkg::STAT_ADDR, 16'h0000);
      rchk(csr_pkg::CFG_ADDR, 16'h6301);
      rchk(csr_pkg::CTL_ADDR, 16'h2140);
      @(posedge clk_in);
      srst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      srst_in <= 1'b0;
      rchk(csr_pkg::CFG_ADDR, 16'h0000);
      rchk(csr_pkg::CTL_ADDR, 16'h0000);
      // Internal bit clock and frame sync rates
      for (i = 0; i < 5; i++) begin
         cfgset(icfg[i], ictl[i]);
         measure(1'b0, per, hi);
         check(per[15:0], sckp[i][15:0]);
         check(hi[15:0], 16'(sckp[i] / 2));
         check({14'h0000, sck_oe_out, fs_oe_out}, 16'h0003);
         if (fsp[i] != 0) begin
            measure(1'b1, per, hi);
            check(per[15:0], fsp[i][15:0]);
            check(hi[15:0], fsh[i][15:0]);
         end
      end
      tally_and_finish();
   end
endmodule : codec_serial_rx_clockgen_tb
